// ### cls_pkg.sv
// cls_pkg: constants, timing counts and state types of the cut line sequencer
package cls_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned WATCHDOG_MS = 10000;
  localparam int unsigned COAST_MS = 2000;
  localparam int unsigned MS_W = 14;
  localparam int unsigned PRESS_MS_W = 10;
  localparam logic [MS_W-1:0] SHEAR_DOWN_MAX_MS = 14'h270f;
  localparam logic [MS_W-1:0] SHEAR_GAP_MAX_MS = 14'h270f;
  localparam logic [MS_W-1:0] PRESS_DOWN_MAX_MS = 14'h03e7;
  localparam logic [MS_W-1:0] MS_ZERO = 14'h0000;
  // synchronised pin vector positions
  localparam int unsigned PIN_N = 12;
  localparam int unsigned PIN_RUN_KEY = 0;
  localparam int unsigned PIN_HALT_KEY = 1;
  localparam int unsigned PIN_EXT_RUN = 2;
  localparam int unsigned PIN_EXT_HALT = 3;
  localparam int unsigned PIN_ESTOP = 4;
  localparam int unsigned PIN_OVERLOAD = 5;
  localparam int unsigned PIN_JOG_FWD = 6;
  localparam int unsigned PIN_JOG_REV = 7;
  localparam int unsigned PIN_MAN_SHEAR = 8;
  localparam int unsigned PIN_MAN_PRESS = 9;
  localparam int unsigned PIN_SHEAR_DONE = 10;
  localparam int unsigned PIN_PRESS_DONE = 11;
  localparam logic [PIN_N-1:0] PIN_RST = 12'h000;
  // motion vector {forward, fast, slow, reverse}
  localparam int unsigned MOT_FWD = 3;
  localparam int unsigned MOT_FAST = 2;
  localparam int unsigned MOT_SLOW = 1;
  localparam int unsigned MOT_REV = 0;
  localparam logic [3:0] MOT_RST = 4'h0;
  typedef enum logic [1:0] {
    CLS_HALT = 2'b00,
    CLS_RUN = 2'b01,
    CLS_COAST = 2'b11
  } cls_run_t;
  typedef enum logic [1:0] {
    CLS_IDLE = 2'b00,
    CLS_DOWN = 2'b01,
    CLS_GAP = 2'b11,
    CLS_UP = 2'b10
  } cls_phase_t;
endpackage : cls_pkg

// ### cls_stroke.sv
// cls_stroke: down, deadband and up stroke timer with complete-switch override and watchdog
module cls_stroke
  import cls_pkg::*;
#(
  parameter logic [MS_W-1:0] DOWN_MAX = SHEAR_DOWN_MAX_MS,
  parameter int unsigned WD_MS = WATCHDOG_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic done_in,
  input wire logic boost_mode_in,
  input wire logic [MS_W-1:0] down_ms_in,
  input wire logic [MS_W-1:0] gap_ms_in,
  input wire logic [MS_W-1:0] up_ms_in,
  cls_stroke_if.unit st
);
  localparam logic [MS_W-1:0] WD_LAST = MS_W'(WD_MS - 1);
  cls_phase_t ph_q, ph_d;
  logic [MS_W-1:0] cnt_q, cnt_d, wd_q, wd_d, dn, gap;
  logic wd_on_q, wd_on_d, to_q, to_d, wd_hit;

  always_comb begin
    dn = (down_ms_in > DOWN_MAX) ? DOWN_MAX : down_ms_in;
    gap = (gap_ms_in > SHEAR_GAP_MAX_MS) ? SHEAR_GAP_MAX_MS : gap_ms_in;
    ph_d = ph_q;
    cnt_d = (tick_in && ph_q != CLS_IDLE) ? cnt_q + MS_W'(1) : cnt_q;
    wd_on_d = wd_on_q;
    wd_d = (tick_in && wd_on_q) ? wd_q + MS_W'(1) : wd_q;
    wd_hit = wd_on_q && tick_in && (wd_q >= WD_LAST);
    to_d = 1'b0;
    if (wd_on_q && done_in) begin
      wd_on_d = 1'b0;
    end else if (wd_hit) begin
      wd_on_d = 1'b0;
      to_d = 1'b1;
    end
    case (ph_q)
      CLS_IDLE: begin
        if (st.fire) begin
          ph_d = CLS_DOWN;
          cnt_d = MS_ZERO;
          wd_on_d = 1'b1;
          wd_d = MS_ZERO;
        end
      end
      CLS_DOWN: begin
        // zero dwell means hold until the complete switch closes or the watchdog fires
        if (done_in || wd_hit || (dn != MS_ZERO && cnt_q >= dn)) begin
          ph_d = (gap == MS_ZERO) ? CLS_UP : CLS_GAP;
          cnt_d = MS_ZERO;
        end
      end
      CLS_GAP: begin
        if (cnt_q >= gap) begin
          ph_d = CLS_UP;
          cnt_d = MS_ZERO;
        end
      end
      CLS_UP: begin
        if (cnt_q >= up_ms_in) begin
          ph_d = CLS_IDLE;
        end
      end
      default: begin
        ph_d = CLS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph_q <= CLS_IDLE;
      cnt_q <= MS_ZERO;
      wd_q <= MS_ZERO;
      wd_on_q <= 1'b0;
      to_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      wd_q <= wd_d;
      wd_on_q <= wd_on_d;
      to_q <= to_d;
    end
  end

  assign st.down = (ph_q == CLS_DOWN);
  assign st.up = (ph_q == CLS_UP) && !boost_mode_in;
  assign st.boost = (ph_q == CLS_UP) && boost_mode_in;
  assign st.busy = (ph_q != CLS_IDLE);
  assign st.waiting = (ph_q == CLS_DOWN) && (dn == MS_ZERO);
  assign st.timeout = to_q;

  property p_done_ends_down;
    @(posedge clk_in) disable iff (rst_in) (ph_q == CLS_DOWN && done_in) |=> ph_q != CLS_DOWN;
  endproperty
  a_done_ends_down: assert property (p_done_ends_down) else $error("down held after complete");
  property p_up_full;
    @(posedge clk_in) disable iff (rst_in) (ph_q == CLS_UP && cnt_q < up_ms_in && $stable(up_ms_in))
      |=> ph_q == CLS_UP;
  endproperty
  a_up_full: assert property (p_up_full) else $error("up stroke cut short");
  property p_down_timed;
    @(posedge clk_in) disable iff (rst_in) (ph_q == CLS_DOWN && dn != MS_ZERO && cnt_q < dn && !done_in
      && !wd_hit) |=> ph_q == CLS_DOWN;
  endproperty
  a_down_timed: assert property (p_down_timed) else $error("down stroke ended early");
  property p_watchdog;
    @(posedge clk_in) disable iff (rst_in) to_q |-> $past(wd_q) == WD_LAST;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog fired at wrong count");
  c_gap: cover property (@(posedge clk_in) disable iff (rst_in) ph_q == CLS_GAP ##1 ph_q == CLS_UP);
endmodule : cls_stroke

// ### cls_stroke_if.sv
// cls_stroke_if: firing request and stroke outputs between sequencer and stroke timer
interface cls_stroke_if;
  logic fire;
  logic down;
  logic up;
  logic boost;
  logic busy;
  logic waiting;
  logic timeout;
  modport ctl (output fire, input down, up, boost, busy, waiting, timeout);
  modport unit (input fire, output down, up, boost, busy, waiting, timeout);
endinterface : cls_stroke_if

// ### cls_switch_model.sv
// cls_switch_model: stroke-complete limit switches that close some time after the down solenoid fires
module cls_switch_model (
  input wire logic clk_in,
  input wire logic [1:0] mode_in,
  input wire logic shear_down_in,
  input wire logic press_down_in,
  output logic shear_done_out,
  output logic press_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int shear_cnt;
  int press_cnt;
  int close_at;
  // mode 0 never closes, 1 closes promptly, 2 closes late
  assign close_at = (mode_in == 2'h1) ? 3 : 400;
  always @(posedge clk_in) begin
    shear_cnt <= shear_down_in ? shear_cnt + 1 : 0;
    press_cnt <= press_down_in ? press_cnt + 1 : 0;
  end
  // switch opens again as soon as the tool leaves the bottom; open reads as 0
  assign shear_done_out = (mode_in != 2'h0) && shear_down_in && (shear_cnt >= close_at);
  assign press_done_out = (mode_in != 2'h0) && press_down_in && (press_cnt >= close_at);
endmodule : cls_switch_model

// ### cls_tick.sv
// cls_tick: one-millisecond time base pulse from the system clock
module cls_tick #(
  parameter int unsigned CYCLES = cls_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule : cls_tick

// ### cls_top.sv
// cls_top: run/halt sequencing, motion outputs and shear/press cycle gating of a cut-to-length line
module cls_top
  import cls_pkg::*;
#(
  parameter int unsigned TICK_N = TICK_CYCLES,
  parameter int unsigned WD_N = WATCHDOG_MS,
  parameter int unsigned COAST_N = COAST_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_key_in,
  input wire logic halt_key_in,
  input wire logic ext_run_in,
  input wire logic ext_halt_in,
  input wire logic estop_in,
  input wire logic overload_in,
  input wire logic jog_fwd_in,
  input wire logic jog_rev_in,
  input wire logic manual_shear_in,
  input wire logic manual_press_in,
  input wire logic shear_done_in,
  input wire logic press_done_in,
  input wire logic auto_shear_in,
  input wire logic auto_press_in,
  input wire logic slow_req_in,
  input wire logic feed_to_stop_in,
  input wire logic line_move_run_in,
  input wire logic fs_logic_sel_in,
  input wire logic single_speed_in,
  input wire logic closed_loop_in,
  input wire logic cut_after_halt_in,
  input wire logic post_cut_en_in,
  input wire logic [MS_W-1:0] post_cut_ms_in,
  input wire logic [3:0] motion_enable_in,
  input wire logic shear_boost_mode_in,
  input wire logic press_boost_mode_in,
  input wire logic [MS_W-1:0] shear_down_ms_in,
  input wire logic [MS_W-1:0] shear_gap_ms_in,
  input wire logic [MS_W-1:0] shear_up_ms_in,
  input wire logic [PRESS_MS_W-1:0] press_down_ms_in,
  input wire logic [MS_W-1:0] press_up_ms_in,
  output logic forward_out,
  output logic fast_out,
  output logic slow_out,
  output logic reverse_out,
  output logic run_out,
  output logic shear_down_out,
  output logic shear_up_out,
  output logic cut_tool_boost_out,
  output logic press_down_out,
  output logic press_up_out,
  output logic punch_tool_boost_out,
  output logic running_out
);
  localparam logic [MS_W-1:0] COAST_LAST = MS_W'(COAST_N - 1);

  // {forward, fast, slow, reverse} for a given machine condition
  function automatic logic [3:0] motion_decode(input logic fs, input logic moving, input logic slow,
                                               input logic jf, input logic jr);
    logic [3:0] m;
    m = MOT_RST;
    if (fs) begin
      if (moving) m = {1'b1, 1'b0, slow, 1'b0};
      else if (jf) m = 4'b1010;
      else if (jr) m = 4'b0011;
      else m = 4'b0010;
    end else begin
      if (moving) m = {1'b1, !slow, 1'b0, 1'b0};
      else if (jf) m = 4'b1000;
      else if (jr) m = 4'b0001;
    end
    return m;
  endfunction : motion_decode

  function automatic logic rise(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : rise

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge history
  logic [PIN_N-1:0] pin_raw, sync1_q, sync2_q, prev_q;
  assign pin_raw = {press_done_in, shear_done_in, manual_press_in, manual_shear_in, jog_rev_in, jog_fwd_in,
                    overload_in, estop_in, ext_halt_in, ext_run_in, halt_key_in, run_key_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          sync1_q[gi] <= PIN_RST[gi];
          sync2_q[gi] <= PIN_RST[gi];
          prev_q[gi] <= PIN_RST[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // time base and stroke timers
  logic tick;
  cls_stroke_if shear_if();
  cls_stroke_if press_if();

  cls_tick #(.CYCLES(TICK_N)) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  cls_stroke #(.DOWN_MAX(SHEAR_DOWN_MAX_MS), .WD_MS(WD_N)) u_shear (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .done_in(sync2_q[PIN_SHEAR_DONE]),
    .boost_mode_in(shear_boost_mode_in),
    .down_ms_in(shear_down_ms_in),
    .gap_ms_in(shear_gap_ms_in),
    .up_ms_in(shear_up_ms_in),
    .st(shear_if.unit)
  );

  // press has no deadband between its strokes
  cls_stroke #(.DOWN_MAX(PRESS_DOWN_MAX_MS), .WD_MS(WD_N)) u_press (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .done_in(sync2_q[PIN_PRESS_DONE]),
    .boost_mode_in(press_boost_mode_in),
    .down_ms_in({{(MS_W-PRESS_MS_W){1'b0}}, press_down_ms_in}),
    .gap_ms_in(MS_ZERO),
    .up_ms_in(press_up_ms_in),
    .st(press_if.unit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // run state
  cls_run_t run_q, run_d;
  logic [MS_W-1:0] coast_q, coast_d;
  logic run_cmd, halt_cmd, stop_lvl, fault, restart_block;

  always_comb begin
    run_cmd = rise(sync2_q[PIN_RUN_KEY], prev_q[PIN_RUN_KEY])
              || rise(sync2_q[PIN_EXT_RUN], prev_q[PIN_EXT_RUN]);
    halt_cmd = rise(sync2_q[PIN_HALT_KEY], prev_q[PIN_HALT_KEY])
               || rise(sync2_q[PIN_EXT_HALT], prev_q[PIN_EXT_HALT]);
    stop_lvl = sync2_q[PIN_ESTOP] || sync2_q[PIN_OVERLOAD];
    // a timed shear may run without a complete switch; only zero dwell waits on it
    fault = (shear_if.timeout && shear_down_ms_in == MS_ZERO) || press_if.timeout;
    restart_block = stop_lvl || (feed_to_stop_in && shear_if.waiting);
    run_d = run_q;
    coast_d = (tick && run_q == CLS_COAST) ? coast_q + MS_W'(1) : coast_q;
    case (run_q)
      CLS_HALT: begin
        if (run_cmd && !restart_block && !halt_cmd) run_d = CLS_RUN;
      end
      CLS_RUN: begin
        if (stop_lvl || fault) begin
          run_d = CLS_HALT;
        end else if (halt_cmd) begin
          run_d = line_move_run_in ? CLS_HALT : CLS_COAST;
          coast_d = MS_ZERO;
        end
      end
      CLS_COAST: begin
        if (stop_lvl || fault) run_d = CLS_HALT;
        else if (run_cmd && !restart_block && !halt_cmd) run_d = CLS_RUN;
        else if (tick && coast_q >= COAST_LAST) run_d = CLS_HALT;
      end
      default: begin
        run_d = CLS_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_q <= CLS_HALT;
      coast_q <= MS_ZERO;
    end else begin
      run_q <= run_d;
      coast_q <= coast_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle gating and post-cut delay
  logic auto_ok, man_shear_ok, man_press_ok, shear_fire, press_fire;
  logic [MS_W-1:0] pc_q, pc_d;

  always_comb begin
    auto_ok = (run_q == CLS_RUN) || (run_q == CLS_COAST && cut_after_halt_in);
    man_shear_ok = (run_q == CLS_HALT) || (run_q == CLS_RUN && !feed_to_stop_in);
    man_press_ok = (run_q == CLS_HALT);
    shear_fire = !shear_if.busy && ((auto_ok && auto_shear_in)
                 || (man_shear_ok && rise(sync2_q[PIN_MAN_SHEAR], prev_q[PIN_MAN_SHEAR])));
    press_fire = !press_if.busy && ((auto_ok && auto_press_in)
                 || (man_press_ok && rise(sync2_q[PIN_MAN_PRESS], prev_q[PIN_MAN_PRESS])));
    pc_d = (tick && pc_q != MS_ZERO) ? pc_q - MS_W'(1) : pc_q;
    if (shear_fire && post_cut_en_in) pc_d = post_cut_ms_in;
  end

  assign shear_if.fire = shear_fire;
  assign press_if.fire = press_fire;

  always_ff @(posedge clk_in) begin
    if (rst_in) pc_q <= MS_ZERO;
    else pc_q <= pc_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic fs_logic, moving, jog_f, jog_r;
  logic [3:0] mot_d, mot_q;
  logic run_o_d, run_o_q;
  logic [5:0] stroke_d, stroke_q;

  always_comb begin
    fs_logic = single_speed_in || (closed_loop_in && motion_enable_in[MOT_FWD] && motion_enable_in[MOT_SLOW])
               || fs_logic_sel_in;
    // coasting material is not driven, only the run output (and slow under fs_logic) lingers
    moving = (run_d == CLS_RUN) && (pc_d == MS_ZERO);
    jog_f = (run_d == CLS_HALT) && sync2_q[PIN_JOG_FWD] && !sync2_q[PIN_JOG_REV];
    jog_r = (run_d == CLS_HALT) && sync2_q[PIN_JOG_REV] && !sync2_q[PIN_JOG_FWD];
    mot_d = motion_decode(fs_logic, moving, slow_req_in, jog_f, jog_r) & motion_enable_in;
    run_o_d = (run_d != CLS_HALT);
    stroke_d = {shear_if.down, shear_if.up, shear_if.boost, press_if.down, press_if.up, press_if.boost};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mot_q <= MOT_RST;
      run_o_q <= 1'b0;
      stroke_q <= 6'h00;
    end else begin
      mot_q <= mot_d;
      run_o_q <= run_o_d;
      stroke_q <= stroke_d;
    end
  end

  assign forward_out = mot_q[MOT_FWD];
  assign fast_out = mot_q[MOT_FAST];
  assign slow_out = mot_q[MOT_SLOW];
  assign reverse_out = mot_q[MOT_REV];
  assign run_out = run_o_q;
  assign {shear_down_out, shear_up_out, cut_tool_boost_out, press_down_out, press_up_out,
          punch_tool_boost_out} = stroke_q;
  assign running_out = run_o_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_estop_halts;
    @(posedge clk_in) disable iff (rst_in) stop_lvl |=> run_q == CLS_HALT ##1 !run_out;
  endproperty
  a_estop_halts: assert property (p_estop_halts) else $error("stop input did not halt");
  property p_run_drop;
    @(posedge clk_in) disable iff (rst_in) (run_q == CLS_RUN && halt_cmd && line_move_run_in && !run_cmd)
      |=> ##1 !run_out;
  endproperty
  a_run_drop: assert property (p_run_drop) else $error("run output kept after halt");
  property p_coast_keeps_run;
    @(posedge clk_in) disable iff (rst_in) (run_q == CLS_RUN && halt_cmd && !line_move_run_in && !stop_lvl
      && !fault) |=> ##1 run_out;
  endproperty
  a_coast_keeps_run: assert property (p_coast_keeps_run) else $error("run dropped during coast");
  property p_auto_gate;
    @(posedge clk_in) disable iff (rst_in) (run_q == CLS_HALT
      && !rise(sync2_q[PIN_MAN_SHEAR], prev_q[PIN_MAN_SHEAR])
      && !rise(sync2_q[PIN_MAN_PRESS], prev_q[PIN_MAN_PRESS])) |-> !shear_fire && !press_fire;
  endproperty
  a_auto_gate: assert property (p_auto_gate) else $error("auto shear while halted");
  property p_no_press_in_run;
    @(posedge clk_in) disable iff (rst_in) (run_q == CLS_RUN && !auto_press_in) |-> !press_fire;
  endproperty
  a_no_press_in_run: assert property (p_no_press_in_run) else $error("manual press while running");
  property p_fs_halt;
    @(posedge clk_in) disable iff (rst_in) (fs_logic && run_d == CLS_HALT && !jog_f && !jog_r
      && motion_enable_in == 4'hf) |=> slow_out && !forward_out && !reverse_out && !run_out;
  endproperty
  a_fs_halt: assert property (p_fs_halt) else $error("halt pattern wrong");
  property p_fs_jog_rev;
    @(posedge clk_in) disable iff (rst_in) (fs_logic && jog_r && motion_enable_in == 4'hf)
      |=> slow_out && reverse_out && !forward_out;
  endproperty
  a_fs_jog_rev: assert property (p_fs_jog_rev) else $error("jog reverse pattern wrong");
  property p_post_cut;
    @(posedge clk_in) disable iff (rst_in) (pc_d != MS_ZERO && run_d == CLS_RUN) |=> !forward_out && run_out;
  endproperty
  a_post_cut: assert property (p_post_cut) else $error("forward not dropped after cut");
  property p_mask;
    @(posedge clk_in) disable iff (rst_in) 1'b1 |=> (mot_q & ~$past(motion_enable_in)) == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("unused motion output driven");
  c_run_coast: cover property (@(posedge clk_in) disable iff (rst_in) run_q == CLS_RUN ##1 run_q == CLS_COAST);
  c_crop: cover property (@(posedge clk_in) disable iff (rst_in) run_q == CLS_RUN && shear_fire && !auto_shear_in);
  c_press_to: cover property (@(posedge clk_in) disable iff (rst_in) press_if.timeout);
endmodule : cls_top

// ### test_cls_top.sv
// test_cls_top: self-checking bench for the cut line sequencer
module test_cls_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cls_pkg::*;
  logic clk_in = 0, rst_in = 1, run_key_in = 0, halt_key_in = 0, ext_run_in = 0, ext_halt_in = 0;
  logic estop_in = 0, overload_in = 0, jog_fwd_in = 0, jog_rev_in = 0, manual_shear_in = 0, manual_press_in = 0;
  logic auto_shear_in = 0, auto_press_in = 0, slow_req_in = 0, feed_to_stop_in = 1, line_move_run_in = 1;
  logic fs_logic_sel_in = 0, single_speed_in = 0, closed_loop_in = 0, cut_after_halt_in = 0, post_cut_en_in = 0;
  logic shear_boost_mode_in = 0, press_boost_mode_in = 0, shear_done_in, press_done_in;
  logic [3:0] motion_enable_in = 4'hf;
  logic [MS_W-1:0] post_cut_ms_in = 14'h0005, shear_down_ms_in = 14'h0003, shear_gap_ms_in = 14'h0002;
  logic [MS_W-1:0] shear_up_ms_in = 14'h0003, press_up_ms_in = 14'h0002;
  logic [PRESS_MS_W-1:0] press_down_ms_in = 10'h003;
  logic [1:0] done_mode = 2'h0;
  logic forward_out, fast_out, slow_out, reverse_out, run_out, shear_down_out, shear_up_out, cut_tool_boost_out;
  logic press_down_out, press_up_out, punch_tool_boost_out, running_out;
  int mismatches = 0;
  int num_checks = 0;
  // short tick, watchdog and coast keep the run brief: 1 ms = 10 clocks
  cls_top #(.TICK_N(10), .WD_N(20), .COAST_N(5)) cls_top_i (
    .clk_in(clk_in), .rst_in(rst_in), .run_key_in(run_key_in), .halt_key_in(halt_key_in),
    .ext_run_in(ext_run_in), .ext_halt_in(ext_halt_in), .estop_in(estop_in), .overload_in(overload_in),
    .jog_fwd_in(jog_fwd_in), .jog_rev_in(jog_rev_in), .manual_shear_in(manual_shear_in),
    .manual_press_in(manual_press_in), .shear_done_in(shear_done_in), .press_done_in(press_done_in),
    .auto_shear_in(auto_shear_in), .auto_press_in(auto_press_in), .slow_req_in(slow_req_in),
    .feed_to_stop_in(feed_to_stop_in), .line_move_run_in(line_move_run_in), .fs_logic_sel_in(fs_logic_sel_in),
    .single_speed_in(single_speed_in), .closed_loop_in(closed_loop_in), .cut_after_halt_in(cut_after_halt_in),
    .post_cut_en_in(post_cut_en_in), .post_cut_ms_in(post_cut_ms_in), .motion_enable_in(motion_enable_in),
    .shear_boost_mode_in(shear_boost_mode_in), .press_boost_mode_in(press_boost_mode_in),
    .shear_down_ms_in(shear_down_ms_in), .shear_gap_ms_in(shear_gap_ms_in), .shear_up_ms_in(shear_up_ms_in),
    .press_down_ms_in(press_down_ms_in), .press_up_ms_in(press_up_ms_in), .forward_out(forward_out),
    .fast_out(fast_out), .slow_out(slow_out), .reverse_out(reverse_out), .run_out(run_out),
    .shear_down_out(shear_down_out), .shear_up_out(shear_up_out), .cut_tool_boost_out(cut_tool_boost_out),
    .press_down_out(press_down_out), .press_up_out(press_up_out), .punch_tool_boost_out(punch_tool_boost_out),
    .running_out(running_out));
  cls_switch_model cls_switch_model_i (.clk_in(clk_in), .mode_in(done_mode), .shear_down_in(shear_down_out),
    .press_down_in(press_down_out), .shear_done_out(shear_done_in), .press_done_out(press_done_in));
  always #10 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick(3);
    s = 0;
    tick(1);
  endtask : pulse
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////
  task t_run_halt;
    pulse(run_key_in);
    tick(3);
    check(run_out, 1);
    check(running_out, 1);
    check({forward_out, fast_out}, 2'h3);
    slow_req_in = 1;
    tick(3);
    check({forward_out, fast_out}, 2'h2);
    slow_req_in = 0;
    pulse(ext_halt_in);
    tick(3);
    check(run_out, 0);
    $display("test run_halt done");
  endtask : t_run_halt
  task t_stop_inputs;
    for (int i = 0; i < 2; i++) begin
      pulse(ext_run_in);
      tick(3);
      check(run_out, 1);
      if (i == 0) estop_in = 1;
      else overload_in = 1;
      tick(6);
      check(run_out, 0);
      pulse(run_key_in);
      tick(3);
      check(run_out, 0);
      estop_in = 0;
      overload_in = 0;
      tick(4);
    end
    $display("test stop_inputs done");
  endtask : t_stop_inputs
  task t_coast;
    line_move_run_in = 0;
    pulse(run_key_in);
    tick(3);
    pulse(halt_key_in);
    tick(2);
    check({run_out, forward_out}, 2'h2);
    check(running_out, 1);
    cut_after_halt_in = 1;
    auto_shear_in = 1;
    tick(1);
    auto_shear_in = 0;
    tick(6);
    check(shear_down_out, 1);
    cut_after_halt_in = 0;
    tick(80);
    check(run_out, 0);
    jog_fwd_in = 1;
    tick(6);
    check({forward_out, reverse_out}, 2'h2);
    jog_fwd_in = 0;
    jog_rev_in = 1;
    tick(6);
    check({forward_out, reverse_out}, 2'h1);
    jog_rev_in = 0;
    fs_logic_sel_in = 1;
    tick(6);
    check({forward_out, slow_out, reverse_out, run_out}, 4'h4);
    fs_logic_sel_in = 0;
    line_move_run_in = 1;
    single_speed_in = 1;
    jog_fwd_in = 1;
    tick(6);
    check({forward_out, slow_out, reverse_out, run_out}, 4'hc);
    jog_fwd_in = 0;
    single_speed_in = 0;
    closed_loop_in = 1;
    pulse(run_key_in);
    tick(3);
    check({forward_out, slow_out, reverse_out, run_out}, 4'h9);
    slow_req_in = 1;
    tick(3);
    check({forward_out, slow_out, reverse_out, run_out}, 4'hd);
    slow_req_in = 0;
    pulse(halt_key_in);
    tick(3);
    check({forward_out, slow_out, reverse_out, run_out}, 4'h4);
    closed_loop_in = 0;
    $display("test coast done");
  endtask : t_coast
  task t_shear;
    post_cut_en_in = 1;
    pulse(run_key_in);
    tick(3);
    auto_shear_in = 1;
    tick(1);
    auto_shear_in = 0;
    tick(14);
    check(shear_down_out, 1);
    check({run_out, forward_out}, 2'h2);
    post_cut_en_in = 0;
    tick(25);
    check({shear_down_out, shear_up_out}, 2'h0);
    tick(20);
    check(shear_up_out, 1);
    tick(75);
    done_mode = 2'h1;
    shear_boost_mode_in = 1;
    auto_shear_in = 1;
    tick(1);
    auto_shear_in = 0;
    tick(14);
    check(shear_down_out, 0);
    tick(25);
    check({shear_up_out, cut_tool_boost_out}, 2'h1);
    tick(60);
    done_mode = 2'h0;
    shear_boost_mode_in = 0;
    feed_to_stop_in = 0;
    pulse(manual_shear_in);
    tick(8);
    check(shear_down_out, 1);
    tick(100);
    feed_to_stop_in = 1;
    pulse(halt_key_in);
    tick(3);
    auto_shear_in = 1;
    tick(1);
    auto_shear_in = 0;
    tick(14);
    check(shear_down_out, 0);
    $display("test shear done");
  endtask : t_shear
  task t_press;
    pulse(manual_press_in);
    tick(10);
    check(press_down_out, 1);
    tick(20);
    check(press_up_out, 1);
    tick(80);
    pulse(ext_run_in);
    tick(3);
    pulse(manual_press_in);
    tick(10);
    check(press_down_out, 0);
    press_down_ms_in = 10'h000;
    press_boost_mode_in = 1;
    auto_press_in = 1;
    tick(1);
    auto_press_in = 0;
    tick(14);
    check({press_down_out, run_out}, 2'h3);
    tick(190);
    check({press_up_out, punch_tool_boost_out}, 2'h1);
    tick(30);
    check(run_out, 0);
    press_boost_mode_in = 0;
    shear_down_ms_in = 14'h0000;
    pulse(manual_shear_in);
    pulse(run_key_in);
    tick(3);
    check({shear_down_out, run_out}, 2'h2);
    tick(220);
    check(shear_down_out, 0);
    shear_down_ms_in = 14'h0003;
    motion_enable_in = 4'h7;
    jog_fwd_in = 1;
    tick(6);
    check({forward_out, reverse_out}, 2'h0);
    jog_fwd_in = 0;
    motion_enable_in = 4'hf;
    $display("test press done");
  endtask : t_press
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    rst_in = 0;
    tick(4);
    check({forward_out, run_out, shear_down_out, press_down_out}, 4'h0);
    t_run_halt;
    t_stop_inputs;
    t_coast;
    t_shear;
    t_press;
    end_sim;
  end
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
endmodule : test_cls_top
